// ==== verif/osc_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module osc_src_model #(
  parameter int HALF = 3
) (
  input wire logic i_clk,  // Bench timebase
  input wire logic i_run,  // Oscillator running
  output logic o_osc       // Level at the oscillator input pin
);
  int cnt = 0;
  initial o_osc = 1'b0;
  // A dead crystal parks at its last level; it does not keep toggling
  always @(posedge i_clk) begin
    if (i_run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) o_osc <= ~o_osc;
    end
  end
endmodule
`default_nettype wire

// ==== verif/system_clock_source_control_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_chk
  import clk_ctrl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_clk_mode_cfg,
  input wire logic i_two_speed_en,
  input wire logic i_wake,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_sys_clk,
  input wire logic o_sys_tick,
  input wire logic o_pc_hold,
  input wire logic [1:0] o_amp_gain,
  input wire logic o_port_a_bit4_gpio,
  input wire logic o_port_a_bit5_gpio,
  input wire logic o_divided_clock_output,
  input wire logic o_divided_clock_output_oe,
  input wire logic o_osc_fail
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_gain_decode: assert property (
    o_amp_gain == ((i_clk_mode_cfg < 3'h3) ? i_clk_mode_cfg[1:0] + 2'h1
                                           : 2'h0))
    else $error("amplifier gain wrong for mode");
  a_bit4_release: assert property (
    o_port_a_bit4_gpio == (i_clk_mode_cfg inside {3'h3, 3'h4, 3'h6}))
    else $error("port bit4 release wrong");
  a_bit5_release: assert property (
    o_port_a_bit5_gpio == (i_clk_mode_cfg inside {3'h4, 3'h5}))
    else $error("port bit5 release wrong");
  a_divided_clock_output_enable: assert property (
    o_divided_clock_output_oe == (i_clk_mode_cfg inside {3'h5, 3'h7}))
    else $error("divided output enable wrong");
  a_divided_clock_output_quiet: assert property (
    !o_divided_clock_output_oe |-> !o_divided_clock_output)
    else $error("divided output toggles while not driven");
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_ext_no_delay: assert property (
    i_wake && i_clk_mode_cfg == 3'h3 |-> ##[1:3] !o_pc_hold)
    else $error("external clock mode delayed start");
  a_crystal_hold: assert property (
    i_wake && i_clk_mode_cfg < 3'h3 && !i_two_speed_en
      |-> ##2 o_pc_hold [*8])
    else $error("program counter not held during crystal start");
  a_fail_sticky: assert property (
    o_osc_fail && !(i_wr && i_addr == STATUS_OFS && i_wdata[3])
      |=> o_osc_fail)
    else $error("failure flag dropped without clear");
  a_tick_on_rise: assert property (
    o_sys_tick == (o_sys_clk && !$past(o_sys_clk)))
    else $error("system tick not on clock rise");
endmodule
bind system_clock_source_control system_clock_source_control_chk u_chk (
  .i_sys_clk, .i_nrst, .i_clk_mode_cfg, .i_two_speed_en, .i_wake,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pc_hold, .o_amp_gain,
  .o_sys_clk, .o_sys_tick,
  .o_port_a_bit4_gpio, .o_port_a_bit5_gpio, .o_divided_clock_output,
  .o_divided_clock_output_oe, .o_osc_fail);
`default_nettype wire

// ==== verif/system_clock_source_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_tb;
  import clk_ctrl_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [2:0] i_clk_mode_cfg = 3'h3;
  logic i_two_speed_en = 1'b0;
  logic i_fail_mon_en = 1'b0;
  logic i_power_up_delay_timer_en = 1'b0;
  logic i_wake = 1'b0;
  wire i_osc_input_pin;
  logic [ADDR_W-1:0] i_addr = 4'h0;
  logic [DATA_W-1:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic o_sys_clk, o_sys_tick, o_pc_hold, o_port_a_bit4_gpio;
  logic o_port_a_bit5_gpio, o_divided_clock_output;
  logic o_divided_clock_output_oe, o_osc_fail;
  logic [1:0] o_amp_gain;
  logic osc_run = 1'b1;
  logic [7:0] d;
  int miscompares = 0;
  int n_tests = 0;
  int n_osc = 0;
  system_clock_source_control #(
    .POWER_UP_DELAY_TIMER_LEN(2),
    .SLOW_HALF(20)
  ) u_system_clock_source_control (
    .i_sys_clk, .i_nrst, .i_clk_mode_cfg, .i_two_speed_en, .i_fail_mon_en,
    .i_power_up_delay_timer_en, .i_wake, .i_osc_input_pin, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_sys_clk, .o_sys_tick, .o_pc_hold, .o_amp_gain,
    .o_port_a_bit4_gpio, .o_port_a_bit5_gpio, .o_divided_clock_output,
    .o_divided_clock_output_oe, .o_osc_fail);
  osc_src_model #(.HALF(3)) u_osc_src_model (
    .i_clk(i_sys_clk), .i_run(osc_run), .o_osc(i_osc_input_pin));
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_osc_input_pin) n_osc++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic wake(input logic [2:0] m);
    @(posedge i_sys_clk);
    i_clk_mode_cfg <= m; i_wake <= 1'b1;
    @(posedge i_sys_clk);
    i_wake <= 1'b0;
  endtask
  task automatic t_regs;
    rd(CTRL_OFS, d); chk(d, 8'h60);
    wr(CTRL_OFS, 8'h71);
    rd(CTRL_OFS, d); chk(d, 8'h71);
    wr(4'hC, 8'hFF);
    rd(4'hC, d); chk(d, 8'h00);
    wr(CTRL_OFS, 8'h60);
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      @(posedge i_sys_clk);
      i_clk_mode_cfg <= m[2:0];
      @(posedge i_sys_clk);
      #1 chk({6'h0, o_amp_gain}, (m < 3) ? m[7:0] + 8'h1 : 8'h0);
      chk({7'h0, o_port_a_bit4_gpio}, (8'h58 >> m) & 8'h01);
      chk({7'h0, o_port_a_bit5_gpio}, (8'h30 >> m) & 8'h01);
      chk({7'h0, o_divided_clock_output_oe}, (8'hA0 >> m) & 8'h01);
    end
    $display("test modes done");
  endtask
  task automatic t_ext_start;
    wake(3'h3);
    repeat (2) @(posedge i_sys_clk);
    #1 chk({7'h0, o_pc_hold}, 8'h00);
    $display("test external start done");
  endtask
  task automatic t_crystal;
    int base;
    wake(3'h1);
    base = n_osc;
    @(posedge i_sys_clk);
    #1 chk({7'h0, o_pc_hold}, 8'h01);
    for (int i = 0; i < 20000 && o_pc_hold; i++) @(posedge i_sys_clk);
    #1 chk({7'h0, o_pc_hold}, 8'h00);
    // Allow a few edges of synchroniser latency around the count
    chk({7'h0, n_osc - base inside {[1024:1030]}}, 8'h01);
    $display("test crystal start done");
  endtask
  task automatic t_divided_clock_output;
    int nd, n0;
    logic pv;
    nd = 0;
    wake(3'h7);
    repeat (40) @(posedge i_sys_clk);
    n0 = n_osc;
    pv = o_divided_clock_output;
    repeat (480) begin
      @(posedge i_sys_clk);
      if (o_divided_clock_output && !pv) nd++;
      pv = o_divided_clock_output;
    end
    chk({7'h0, (nd * 4 - (n_osc - n0)) inside {[-8:8]}}, 8'h01);
    $display("test divided output done");
  endtask
  task automatic t_fail;
    @(posedge i_sys_clk);
    i_fail_mon_en <= 1'b1;
    wake(3'h3);
    repeat (100) @(posedge i_sys_clk);
    osc_run <= 1'b0;
    for (int i = 0; i < 1000 && !o_osc_fail; i++) @(posedge i_sys_clk);
    #1 chk({7'h0, o_osc_fail}, 8'h01);
    rd(CTRL_OFS, d); chk(d, 8'h60);
    wr(STATUS_OFS, 8'h08);
    #1 chk({7'h0, o_osc_fail}, 8'h00);
    $display("test fail monitor done");
  endtask
  task automatic t_two_speed;
    int base;
    @(posedge i_sys_clk);
    i_two_speed_en <= 1'b1;
    osc_run <= 1'b1;
    wake(3'h2);
    base = n_osc;
    // Internal source settles long before the crystal count ends
    repeat (1500) @(posedge i_sys_clk);
    #1 chk({7'h0, o_pc_hold}, 8'h00);
    chk({7'h0, (n_osc - base) < 1024}, 8'h01);
    rd(STATUS_OFS, d); chk(d, 8'h06);
    rd(CTRL_OFS, d); chk(d, 8'h60);
    repeat (5200) @(posedge i_sys_clk);
    rd(STATUS_OFS, d); chk(d, 8'h03);
    $display("test two-speed start done");
  endtask
  task automatic complete_run;
    $display("tests=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    t_regs();
    t_modes();
    t_ext_start();
    t_crystal();
    t_divided_clock_output();
    t_fail();
    t_two_speed();
    complete_run();
  end
  // Whole run needs about 14k cycles; cut a hang well beyond that
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire

// ==== verilog/clk_ctrl_pkg.sv ====
`default_nettype none
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock modes from the configuration field
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    low_gain_crystal_mode         = 3'h0,
    medium_gain_crystal_mode      = 3'h1,
    high_gain_crystal_mode        = 3'h2,
    ext_clock_in_mode             = 3'h3,
    internal_osc_all_io_mode      = 3'h4,
    internal_osc_divided_out_mode = 3'h5,
    resistor_cap_osc_pin_io_mode  = 3'h6,
    resistor_cap_osc_divided_clock_output_mode  = 3'h7
  } clk_mode_t;

  // Start-up sequence, Gray coded along off, power-up, start, run
  typedef enum logic [1:0] {
    st_off  = 2'b00,
    st_power_up_delay_timer = 2'b01,
    st_ost  = 2'b11,
    st_run  = 2'b10
  } startup_t;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam int CTRL_SCS_BIT = 0;
  localparam int CTRL_INTERNAL_FREQ_SELECT_LSB = 4;
  localparam int STAT_EXT_RUN_BIT = 0;
  localparam int STAT_INT_RDY_BIT = 1;
  localparam int STAT_CUR_INT_BIT = 2;
  localparam int STAT_FAIL_BIT = 3;
  localparam int STAT_PC_HOLD_BIT = 4;
  localparam logic SCS_RESET = 1'b0;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h6;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_SLOW = 3'h0;

  // ----------------------------------------------------------------
  // Amplifier gain codes
  // ----------------------------------------------------------------
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_MED = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int FAST_OSC_HZ = 8_000_000;
  localparam int SLOW_OSC_HZ = 31_000;
  localparam int FAST_HALF_CYC = SYS_CLK_HZ / (2 * FAST_OSC_HZ);
  localparam int SLOW_HALF_CYC = SYS_CLK_HZ / (2 * SLOW_OSC_HZ);
  localparam int FAST_WAKE_NS = 1000;
  localparam int INT_START_NS = 5000;
  localparam int FAST_WAKE_CYC =
    (FAST_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_START_CYC =
    (INT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_EDGES = 1024;
  localparam int POWER_UP_DELAY_TIMER_TICKS = 64;
  localparam int STAB_W = 12;
  localparam int OST_W = 11;
  localparam int DIV_W = 13;

  function automatic logic is_crystal(input clk_mode_t m);
    return (m == low_gain_crystal_mode) ||
           (m == medium_gain_crystal_mode) ||
           (m == high_gain_crystal_mode);
  endfunction

  function automatic logic is_internal(input clk_mode_t m);
    return (m == internal_osc_all_io_mode) ||
           (m == internal_osc_divided_out_mode);
  endfunction

endpackage
`default_nettype wire

// ==== verilog/clk_mux_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface clk_mux_if;
  logic src_ext;
  logic src_int;
  logic sel_int;
  logic clk_out;
  logic rise;
  logic cur_int;
  logic busy;
  modport ctrl (output src_ext, src_int, sel_int,
                input clk_out, rise, cur_int, busy);
  modport mux (input src_ext, src_int, sel_int,
               output clk_out, rise, cur_int, busy);
endinterface
`default_nettype wire

// ==== verilog/glitch_free_clk_mux.sv ====
`timescale 1ns/1ps
`default_nettype none
module glitch_free_clk_mux
  import clk_ctrl_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_nrst,    // Async reset, active low
  clk_mux_if.mux bus          // Source levels in, switched clock out
);

  typedef enum logic [1:0] {
    mx_follow    = 2'b00,
    mx_wait_fall = 2'b01,
    mx_wait_rise = 2'b11
  } mux_state_t;

  mux_state_t state_reg, state_next;
  logic ext_q_reg, int_q_reg;
  logic cur_reg, cur_next;
  logic out_reg, out_next;
  logic rise_reg;
  logic old_lvl, new_lvl, old_fall, new_rise;

  assign old_lvl = cur_reg ? bus.src_int : bus.src_ext;
  assign new_lvl = cur_reg ? bus.src_ext : bus.src_int;
  assign old_fall = cur_reg ? (int_q_reg & ~bus.src_int)
                            : (ext_q_reg & ~bus.src_ext);
  assign new_rise = cur_reg ? (~ext_q_reg & bus.src_ext)
                            : (~int_q_reg & bus.src_int);

  // ----------------------------------------------------------------
  // Switch sequence: old falls, output held low, new rises
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    out_next = out_reg;
    unique case (state_reg)
      mx_follow: begin
        out_next = old_lvl;
        if (bus.sel_int != cur_reg) begin
          state_next = mx_wait_fall;
        end
      end
      mx_wait_fall: begin
        out_next = old_lvl;
        if (old_fall) begin
          out_next = 1'b0;
          state_next = mx_wait_rise;
        end
      end
      mx_wait_rise: begin
        out_next = 1'b0;
        if (bus.sel_int == cur_reg) begin
          state_next = mx_follow;
        end else if (new_rise) begin
          cur_next = ~cur_reg;
          out_next = new_lvl;
          state_next = mx_follow;
        end
      end
      default: begin
        state_next = mx_follow;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= mx_follow;
      cur_reg <= 1'b1;
      out_reg <= 1'b0;
      rise_reg <= 1'b0;
      ext_q_reg <= 1'b0;
      int_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      out_reg <= out_next;
      rise_reg <= out_next & ~out_reg;
      ext_q_reg <= bus.src_ext;
      int_q_reg <= bus.src_int;
    end
  end

  assign bus.clk_out = out_reg;
  assign bus.rise = rise_reg;
  assign bus.cur_int = cur_reg;
  assign bus.busy = (state_reg != mx_follow);

endmodule
`default_nettype wire

// ==== verilog/system_clock_source_control.sv ====
// Overview of operation
// - Three-bit field picks one of eight clock modes.
// - External clock mode clocks from input pin; port A bit 4 freed.
// - RC with output drives the output pin with RC clock over four.
// - RC with I/O keeps RC on input pin; output pin is GPIO.
// - Internal with output drives clock over four on bit 4; bit 5 GPIO.
// - Internal with full I/O frees port A bits 4 and 5.
// - Crystal modes count 1024 input cycles after power-up or wake.
// - Program counter held while the crystal start count runs without two-speed start.
// - External clock mode skips the start count entirely.
// - Logic is static; a stopped clock freezes state, restart resumes.
// - Amplifier gain low, medium, high per crystal mode.
// - Wait 1 us slow-to-fast, 5 us after power-up or wake.
// - Fast 8 MHz and slow 31 kHz internal sources exist.
// - Fail monitor spots lost external clock and selects internal; the mux keeps waiting for the stopped clock to fall.
// - Software chooses external or internal system clock.
// - Two-speed start runs code on internal clock during crystal start.
// - Select bit clears on reset; zero uses mode, one uses frequency.
// - Frequency field resets to 110, the 4 MHz setting.
// - Slow source times power-up and fail monitor always.
// - Automatic switches never change the select bit.
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control
  import clk_ctrl_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_LEN = POWER_UP_DELAY_TIMER_TICKS,        // Power-up timer slow ticks
  parameter int SLOW_HALF = SLOW_HALF_CYC     // Slow source half period
) (
  input wire logic i_sys_clk,                 // 250 MHz clock
  input wire logic i_nrst,                    // Async reset, active low
  input wire logic [2:0] i_clk_mode_cfg,      // Clock mode field
  input wire logic i_two_speed_en,            // Two-speed start enable
  input wire logic i_fail_mon_en,             // Clock fail monitor enable
  input wire logic i_power_up_delay_timer_en,                 // Power-up timer enable
  input wire logic i_wake,                    // Wake from sleep pulse
  input wire logic i_osc_input_pin,           // Oscillator input level
  input wire logic [ADDR_W-1:0] i_addr,       // Register address
  input wire logic [DATA_W-1:0] i_wdata,      // Write data
  input wire logic i_wr,                      // Write strobe
  input wire logic i_rd,                      // Read strobe
  output logic [DATA_W-1:0] o_rdata,          // Read data, next cycle
  output logic o_sys_clk,                     // Switched system clock
  output logic o_sys_tick,                    // Pulse on sys clock rise
  output logic o_pc_hold,                     // Hold program counter
  output logic [1:0] o_amp_gain,              // Amplifier gain code
  output logic o_port_a_bit4_gpio,            // Bit 4 free for GPIO
  output logic o_port_a_bit5_gpio,            // Bit 5 free for GPIO
  output logic o_divided_clock_output,        // Sys clock over four
  output logic o_divided_clock_output_oe,     // Drive enable of above
  output logic o_osc_fail                     // Failure flag
);

  clk_mux_if mux_bus();

  clk_mode_t mode;
  startup_t state_reg;
  logic scs_reg;
  logic [2:0] internal_freq_select_reg;
  logic fail_flag_reg, fallback_reg;
  logic ext_q_reg, ext_seen_reg;
  logic [OST_W-1:0] ost_cnt_reg;
  logic [STAB_W-1:0] stab_cnt_reg;
  logic [DIV_W-1:0] slow_cnt_reg;
  logic slow_lvl_reg, slow_tick;
  logic [3:0] fast_cnt_reg;
  logic fast_lvl_reg, fast_on_q_reg;
  logic [5:0] ps_cnt_reg;
  logic [11:0] power_up_delay_timer_cnt_reg;
  logic [1:0] div_cnt_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic ext_rise, int_rdy, int_lvl, fast_on, restart;
  logic two_spd_run, monitoring, fail_evt, ext_running;
  logic wr_ctrl, wr_stat;

  assign mode = clk_mode_t'(i_clk_mode_cfg);
  assign ext_rise = i_osc_input_pin & ~ext_q_reg;
  assign wr_ctrl = i_wr && (i_addr == CTRL_OFS);
  assign wr_stat = i_wr && (i_addr == STATUS_OFS);

  // ----------------------------------------------------------------
  // Software clock choice
  // ----------------------------------------------------------------
  // Only software writes touch these; fallback and two-speed leave
  // them alone so software can still see what it asked for.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scs_reg <= SCS_RESET;
      internal_freq_select_reg <= INTERNAL_FREQ_SELECT_RESET;
    end else if (wr_ctrl) begin
      scs_reg <= i_wdata[CTRL_SCS_BIT];
      internal_freq_select_reg <= i_wdata[CTRL_INTERNAL_FREQ_SELECT_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Internal oscillators
  // ----------------------------------------------------------------
  // Slow source runs free: it times power-up and the fail monitor.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      slow_cnt_reg <= '0;
      slow_lvl_reg <= 1'b0;
    end else if (slow_cnt_reg == DIV_W'(SLOW_HALF - 1)) begin
      slow_cnt_reg <= '0;
      slow_lvl_reg <= ~slow_lvl_reg;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 1'b1;
    end
  end
  assign slow_tick = (slow_cnt_reg == DIV_W'(SLOW_HALF - 1)) &
                     ~slow_lvl_reg;

  // Fast source and its postscaler only run when asked for
  assign fast_on = (internal_freq_select_reg != INTERNAL_FREQ_SELECT_SLOW) && (mux_bus.sel_int ||
                   mux_bus.cur_int);
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fast_cnt_reg <= '0;
      fast_lvl_reg <= 1'b0;
      ps_cnt_reg <= '0;
    end else if (!fast_on) begin
      fast_cnt_reg <= '0;
      fast_lvl_reg <= 1'b0;
    end else if (fast_cnt_reg == 4'(FAST_HALF_CYC - 1)) begin
      fast_cnt_reg <= '0;
      fast_lvl_reg <= ~fast_lvl_reg;
      if (!fast_lvl_reg) begin
        ps_cnt_reg <= ps_cnt_reg + 1'b1;
      end
    end else begin
      fast_cnt_reg <= fast_cnt_reg + 1'b1;
    end
  end

  // Settling delay; the mux only sees a level once it is ready
  assign restart = i_wake || (state_reg == st_off);
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stab_cnt_reg <= '0;
      fast_on_q_reg <= 1'b0;
    end else begin
      fast_on_q_reg <= fast_on;
      if (restart) begin
        stab_cnt_reg <= STAB_W'(INT_START_CYC);
      end else if (fast_on && !fast_on_q_reg && stab_cnt_reg == '0) begin
        stab_cnt_reg <= STAB_W'(FAST_WAKE_CYC);
      end else if (stab_cnt_reg != '0) begin
        stab_cnt_reg <= stab_cnt_reg - 1'b1;
      end
    end
  end
  assign int_rdy = (stab_cnt_reg == '0);

  always_comb begin
    unique case (internal_freq_select_reg)
      3'h7: int_lvl = fast_lvl_reg;
      3'h6: int_lvl = ps_cnt_reg[0];
      3'h5: int_lvl = ps_cnt_reg[1];
      3'h4: int_lvl = ps_cnt_reg[2];
      3'h3: int_lvl = ps_cnt_reg[3];
      3'h2: int_lvl = ps_cnt_reg[4];
      3'h1: int_lvl = ps_cnt_reg[5];
      3'h0: int_lvl = slow_lvl_reg;
    endcase
  end

  // ----------------------------------------------------------------
  // Start-up sequence
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= st_off;
      power_up_delay_timer_cnt_reg <= '0;
      ost_cnt_reg <= '0;
      ext_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= i_osc_input_pin;
      if (i_wake) begin
        state_reg <= st_ost;
        ost_cnt_reg <= '0;
      end else begin
        unique case (state_reg)
          st_off: begin
            power_up_delay_timer_cnt_reg <= '0;
            ost_cnt_reg <= '0;
            state_reg <= i_power_up_delay_timer_en ? st_power_up_delay_timer : st_ost;
          end
          st_power_up_delay_timer: begin
            if (power_up_delay_timer_cnt_reg == 12'(POWER_UP_DELAY_TIMER_LEN)) begin
              state_reg <= st_ost;
            end else if (slow_tick) begin
              power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + 1'b1;
            end
          end
          st_ost: begin
            if (is_crystal(mode)) begin
              if (ost_cnt_reg == OST_W'(OST_EDGES)) begin
                state_reg <= st_run;
              end else if (ext_rise) begin
                ost_cnt_reg <= ost_cnt_reg + 1'b1;
              end
            end else if (is_internal(mode)) begin
              if (int_rdy) begin
                state_reg <= st_run;
              end
            end else begin
              state_reg <= st_run;
            end
          end
          st_run: begin
            state_reg <= st_run;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Fail monitor, paced by the slow source
  // ----------------------------------------------------------------
  assign monitoring = i_fail_mon_en && !is_internal(mode) &&
                      state_reg == st_run && !fallback_reg;
  assign fail_evt = monitoring && slow_tick && !ext_seen_reg;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_seen_reg <= 1'b0;
      fallback_reg <= 1'b0;
    end else begin
      if (slow_tick) begin
        ext_seen_reg <= ext_rise;
      end else if (ext_rise) begin
        ext_seen_reg <= 1'b1;
      end
      if (i_wake) begin
        fallback_reg <= 1'b0;
      end else if (fail_evt) begin
        fallback_reg <= 1'b1;
      end
    end
  end

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fail_flag_reg <= 1'b0;
    end else if (fail_evt) begin
      fail_flag_reg <= 1'b1;
    end else if (wr_stat && i_wdata[STAT_FAIL_BIT]) begin
      fail_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and glitch-free switch
  // ----------------------------------------------------------------
  assign two_spd_run = i_two_speed_en && is_crystal(mode) &&
                       state_reg != st_run;
  assign mux_bus.src_ext = i_osc_input_pin;
  assign mux_bus.src_int = int_lvl & int_rdy;
  assign mux_bus.sel_int = scs_reg || is_internal(mode) ||
                           fallback_reg || two_spd_run;

  glitch_free_clk_mux u_mux (
    .i_sys_clk (i_sys_clk),
    .i_nrst (i_nrst),
    .bus (mux_bus.mux)
  );

  // A stopped external clock simply stops the ticks; nothing resets
  assign o_sys_clk = mux_bus.clk_out;
  assign o_sys_tick = mux_bus.rise;
  assign ext_running = (state_reg == st_run) && !mux_bus.cur_int;
  assign o_pc_hold = (state_reg != st_run) &&
                     !(two_spd_run && mux_bus.cur_int &&
                       !mux_bus.busy);

  // ----------------------------------------------------------------
  // Pins and amplifier
  // ----------------------------------------------------------------
  always_comb begin
    unique case (mode)
      low_gain_crystal_mode: o_amp_gain = GAIN_LOW;
      medium_gain_crystal_mode: o_amp_gain = GAIN_MED;
      high_gain_crystal_mode: o_amp_gain = GAIN_HIGH;
      default: o_amp_gain = GAIN_OFF;
    endcase
  end

  assign o_port_a_bit4_gpio = (mode == ext_clock_in_mode) ||
                              (mode == resistor_cap_osc_pin_io_mode) ||
                              (mode == internal_osc_all_io_mode);
  assign o_port_a_bit5_gpio = is_internal(mode);
  assign o_divided_clock_output_oe =
    (mode == resistor_cap_osc_divided_clock_output_mode) ||
    (mode == internal_osc_divided_out_mode);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt_reg <= '0;
    end else if (mux_bus.rise) begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end
  assign o_divided_clock_output = div_cnt_reg[1] &
                                  o_divided_clock_output_oe;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= '0;
    end else if (i_rd) begin
      rdata_reg <= '0;
      if (i_addr == CTRL_OFS) begin
        rdata_reg[CTRL_SCS_BIT] <= scs_reg;
        rdata_reg[CTRL_INTERNAL_FREQ_SELECT_LSB +: 3] <= internal_freq_select_reg;
      end else if (i_addr == STATUS_OFS) begin
        rdata_reg[STAT_EXT_RUN_BIT] <= ext_running;
        rdata_reg[STAT_INT_RDY_BIT] <= int_rdy;
        rdata_reg[STAT_CUR_INT_BIT] <= mux_bus.cur_int;
        rdata_reg[STAT_FAIL_BIT] <= fail_flag_reg;
        rdata_reg[STAT_PC_HOLD_BIT] <= o_pc_hold;
      end
    end else begin
      rdata_reg <= '0;
    end
  end
  assign o_rdata = rdata_reg;
  assign o_osc_fail = fail_flag_reg;

endmodule
`default_nettype wire
